// file: rpc_pkg.sv
/*
 * Constants shared by the reset pin controller: clock rate, pin drive-back
 * length, synchroniser settle time and power-on reset stretch.
 * Assumes a single 20 MHz system clock.
 */
package rpc_pkg;
   localparam int CLK_PERIOD_NS     = 50;
   localparam int SYNC_STAGES       = 2;
   // drive-back length is counted in system clock cycles
   localparam int DRIVE_CYCLES      = 6;
   // after letting go of the pin, wait out the synchroniser before sensing again
   localparam int SETTLE_CYCLES     = SYNC_STAGES + 1;
   localparam int POR_HOLD_NS       = 800;
   localparam int POR_HOLD_CYCLES   = (POR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W             = 8;
   localparam logic SYNC_RESET_VAL  = 1'b1;
endpackage

// file: rpc_sync.sv
/*
 * Multi-bit two-stage (or deeper) level synchroniser for pin inputs.
 * Assumes each bit is an independent level; no word coherence is given.
 */
`timescale 1ns/1ps
`default_nettype none
module rpc_sync #(
   parameter int   WIDTH  = 2,
   parameter int   STAGES = rpc_pkg::SYNC_STAGES,
   parameter logic RVAL   = rpc_pkg::SYNC_RESET_VAL
) (
   input  wire logic             ref_clk,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] d,
   output var  logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] stage [STAGES];
   logic [WIDTH-1:0] next_stage [STAGES];

   initial begin
      if (STAGES < 2) begin
         $error("rpc_sync needs at least two stages");
      end
   end

   always_comb begin
      next_stage[0] = d;
      for (int i = 1; i < STAGES; i++) begin
         next_stage[i] = stage[i-1];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < STAGES; i++) begin
            stage[i] <= {WIDTH{RVAL}};
         end
      end else begin
         for (int i = 0; i < STAGES; i++) begin
            stage[i] <= next_stage[i];
         end
      end
   end

   assign q = stage[STAGES-1];
endmodule
`default_nettype wire

// file: rpc_reset_pin_controller.sv
/*
 * Reset pin controller: senses the soft reset pin and the power reset pin,
 * drives the soft reset pin low in bursts while it is seen low, and
 * produces the core, power-on and debug reset levels plus a run enable.
 * Assumes both pin inputs are asynchronous and pulled up outside; the pad
 * resolves the soft pin from out/oe. The real-time clock is not reset here.
 */
`timescale 1ns/1ps
`default_nettype none
// Contract
// - While the soft reset pin is seen low the core stays in reset.
// - When the soft reset pin is seen high again the core, registers and peripherals leave reset.
// - A soft reset leaves the power-on-only registers, clock logic and debug state alone.
// - Sensing the soft reset pin low makes the block drive that pin low.
// - Each drive-low burst lasts exactly six system clock cycles, then the pin is released.
// - Sensing and driving alternate until the pin is sensed high.
// - While the power reset pin is low everything but the clock logic is held in reset.
// - Release of the power reset pin starts a full power-on reset of all but the clock logic.
// - When that power-on reset completes, program execution is enabled.
module rpc_reset_pin_controller #(
   parameter int DRIVE_CYCLES    = rpc_pkg::DRIVE_CYCLES,
   parameter int SETTLE_CYCLES   = rpc_pkg::SETTLE_CYCLES,
   parameter int POR_HOLD_CYCLES = rpc_pkg::POR_HOLD_CYCLES
) (
   input  wire logic ref_clk,
   input  wire logic rst_b,
   input  wire logic soft_reset_pin_n_in,
   output var  logic soft_reset_pin_n_out,
   output var  logic soft_reset_pin_n_oe,
   input  wire logic power_reset_pin_n_in,
   output var  logic core_rst_n,
   output var  logic por_rst_n,
   output var  logic dbg_rst_n,
   output var  logic run_en
);
   typedef enum logic [1:0] {RPC_S_SENSE, RPC_S_DRIVE, RPC_S_SETTLE} rpc_soft_t;
   typedef enum logic [1:0] {RPC_P_HOLD, RPC_P_POR, RPC_P_RUN} rpc_pwr_t;

   localparam int MAXC = 1 << rpc_pkg::CNT_W;
   localparam logic [rpc_pkg::CNT_W-1:0] DRV_LAST = rpc_pkg::CNT_W'(DRIVE_CYCLES - 1);
   localparam logic [rpc_pkg::CNT_W-1:0] SET_LAST = rpc_pkg::CNT_W'(SETTLE_CYCLES - 1);
   localparam logic [rpc_pkg::CNT_W-1:0] POR_LAST = rpc_pkg::CNT_W'(POR_HOLD_CYCLES - 1);

   initial begin
      if (DRIVE_CYCLES < 1 || DRIVE_CYCLES > MAXC || POR_HOLD_CYCLES < 1 ||
          POR_HOLD_CYCLES > MAXC || SETTLE_CYCLES < rpc_pkg::SYNC_STAGES + 1 ||
          SETTLE_CYCLES > MAXC) begin
         $error("rpc_reset_pin_controller: count parameter out of range");
      end
   end

   logic [1:0] pins_s;
   logic       soft_s;
   logic       pwr_s;

   rpc_sync #(
      .WIDTH  (2),
      .STAGES (rpc_pkg::SYNC_STAGES),
      .RVAL   (rpc_pkg::SYNC_RESET_VAL)
   ) u_sync (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .d       ({power_reset_pin_n_in, soft_reset_pin_n_in}),
      .q       (pins_s)
   );
   assign soft_s = pins_s[0];
   assign pwr_s  = pins_s[1];

   // power reset sequencing
   rpc_pwr_t                  pstate;
   rpc_pwr_t                  next_pstate;
   logic [rpc_pkg::CNT_W-1:0] pcnt;
   logic [rpc_pkg::CNT_W-1:0] next_pcnt;
   logic                      next_por_rst_n;
   logic                      next_dbg_rst_n;
   logic                      next_run_en;

   always_comb begin
      next_pstate = pstate;
      next_pcnt   = pcnt;
      unique case (pstate)
         RPC_P_HOLD: begin
            next_pcnt = '0;
            if (pwr_s) begin
               next_pstate = RPC_P_POR;
            end
         end
         RPC_P_POR: begin
            next_pcnt = pcnt + 1'b1;
            if (pcnt == POR_LAST) begin
               next_pstate = RPC_P_RUN;
            end
         end
         RPC_P_RUN: begin
            next_pcnt = '0;
         end
      endcase
      if (!pwr_s) begin
         next_pstate = RPC_P_HOLD;
         next_pcnt   = '0;
      end
      next_por_rst_n = (next_pstate == RPC_P_RUN);
      next_dbg_rst_n = next_por_rst_n;
      // execution starts one cycle after the power-on and debug reset levels rise, with the core level
      next_run_en    = por_rst_n && (next_pstate == RPC_P_RUN);
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pstate    <= RPC_P_HOLD;
         pcnt      <= '0;
         por_rst_n <= 1'b0;
         dbg_rst_n <= 1'b0;
         run_en    <= 1'b0;
      end else begin
         pstate    <= next_pstate;
         pcnt      <= next_pcnt;
         por_rst_n <= next_por_rst_n;
         dbg_rst_n <= next_dbg_rst_n;
         run_en    <= next_run_en;
      end
   end

   // soft reset pin sensing and drive-back
   rpc_soft_t                 sstate;
   rpc_soft_t                 next_sstate;
   logic [rpc_pkg::CNT_W-1:0] scnt;
   logic [rpc_pkg::CNT_W-1:0] next_scnt;
   logic                      next_oe;
   logic                      next_core_rst_n;

   always_comb begin
      next_sstate = sstate;
      next_scnt   = scnt;
      unique case (sstate)
         RPC_S_SENSE: begin
            next_scnt = '0;
            if (!soft_s) begin
               next_sstate = RPC_S_DRIVE;
            end
         end
         RPC_S_DRIVE: begin
            next_scnt = scnt + 1'b1;
            if (scnt == DRV_LAST) begin
               next_sstate = RPC_S_SETTLE;
               next_scnt   = '0;
            end
         end
         RPC_S_SETTLE: begin
            // our own low drive is still in the synchroniser; do not sense it
            next_scnt = scnt + 1'b1;
            if (scnt == SET_LAST) begin
               next_scnt   = '0;
               next_sstate = soft_s ? RPC_S_SENSE : RPC_S_DRIVE;
            end
         end
      endcase
      if (!por_rst_n) begin
         next_sstate = RPC_S_SENSE;
         next_scnt   = '0;
      end
      next_oe = (next_sstate == RPC_S_DRIVE);
      // only the core domain follows the soft pin; por and debug do not
      // gate with the next power-on level too, so a falling power pin drops the core at once
      next_core_rst_n = por_rst_n && next_por_rst_n && soft_s &&
                        (next_sstate == RPC_S_SENSE);
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         sstate               <= RPC_S_SENSE;
         scnt                 <= '0;
         soft_reset_pin_n_oe  <= 1'b0;
         soft_reset_pin_n_out <= 1'b0;
         core_rst_n           <= 1'b0;
      end else begin
         sstate               <= next_sstate;
         scnt                 <= next_scnt;
         soft_reset_pin_n_oe  <= next_oe;
         soft_reset_pin_n_out <= 1'b0;
         core_rst_n           <= next_core_rst_n;
      end
   end

   sequence s_drive_burst;
      soft_reset_pin_n_oe [*6] ##1 !soft_reset_pin_n_oe;
   endsequence

   sequence s_seen_low;
      sstate == RPC_S_SENSE && !soft_s && por_rst_n;
   endsequence

   property p_core_held_low;
      @(posedge ref_clk) disable iff (!rst_b)
         !soft_s |=> !core_rst_n;
   endproperty
   a_core_held_low: assert property (p_core_held_low)
      else $error("core reset released while soft pin low");

   property p_core_release;
      @(posedge ref_clk) disable iff (!rst_b)
         $rose(core_rst_n) |-> $past(soft_s) && $past(por_rst_n);
   endproperty
   a_core_release: assert property (p_core_release)
      else $error("core reset released without soft pin high");

   property p_soft_spares_por;
      @(posedge ref_clk) disable iff (!rst_b)
         por_rst_n && pwr_s && !soft_s |=> por_rst_n && dbg_rst_n;
   endproperty
   a_soft_spares_por: assert property (p_soft_spares_por)
      else $error("soft reset disturbed power-on or debug reset");

   property p_drive_on_low;
      @(posedge ref_clk) disable iff (!rst_b)
         s_seen_low ##1 pwr_s |-> soft_reset_pin_n_oe && !soft_reset_pin_n_out;
   endproperty
   a_drive_on_low: assert property (p_drive_on_low)
      else $error("soft pin not driven low after being sensed low");

   property p_drive_len;
      @(posedge ref_clk) disable iff (!rst_b || !pwr_s || !por_rst_n)
         $rose(soft_reset_pin_n_oe) |-> s_drive_burst;
   endproperty
   a_drive_len: assert property (p_drive_len)
      else $error("drive-low burst not six cycles");

   property p_repeat;
      @(posedge ref_clk) disable iff (!rst_b || !pwr_s || !por_rst_n)
         $fell(soft_reset_pin_n_oe) ##0 !soft_reset_pin_n_in [*4]
            |-> ##[1:3] soft_reset_pin_n_oe;
   endproperty
   a_repeat: assert property (p_repeat)
      else $error("drive-low not repeated while pin low");

   property p_pwr_hold;
      @(posedge ref_clk) disable iff (!rst_b)
         !pwr_s |=> !por_rst_n && !dbg_rst_n && !core_rst_n && !run_en;
   endproperty
   a_pwr_hold: assert property (p_pwr_hold)
      else $error("reset released while power pin low");

   property p_por_done;
      @(posedge ref_clk) disable iff (!rst_b)
         pstate == RPC_P_POR && pcnt == POR_LAST && pwr_s |=> por_rst_n;
   endproperty
   a_por_done: assert property (p_por_done)
      else $error("power-on reset not released after its stretch");

   property p_run_after_por;
      @(posedge ref_clk) disable iff (!rst_b)
         $rose(por_rst_n) ##1 pwr_s |-> run_en;
   endproperty
   a_run_after_por: assert property (p_run_after_por)
      else $error("execution not enabled after power-on reset");

   property p_sync_delay;
      @(posedge ref_clk) disable iff (!rst_b)
         !power_reset_pin_n_in [*4] |-> !pwr_s;
   endproperty
   a_sync_delay: assert property (p_sync_delay)
      else $error("power pin not seen through synchroniser");
endmodule
`default_nettype wire

// file: rpc_pad_model.sv
/*
 * Board-side model of the two reset pads: an external source that may pull
 * either pad low, and the pull-up that lifts a pad nobody drives.
 * Assumes the controller drives the soft pad only while its enable is high.
 */
`timescale 1ns/1ps
`default_nettype none
module rpc_pad_model (
   input  wire logic ext_low,
   input  wire logic pwr_low,
   input  wire logic oe,
   input  wire logic out,
   output var  logic soft_pad,
   output var  logic pwr_pad
);
   // wired-and of both drivers; a released pad is lifted by the pull-up
   always_comb begin
      soft_pad = (ext_low || (oe && !out)) ? 1'b0 : 1'b1;
      pwr_pad  = pwr_low ? 1'b0 : 1'b1;
   end
endmodule
`default_nettype wire

// file: testbench.sv
/*
 * Self-checking bench for the reset pin controller: power-on sequencing,
 * soft pin drive-back bursts and reset in mid-burst.
 * Assumes the pad model sits between the bench and both pads.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   typedef struct {int hold; int bursts;} rpc_row_t;
   logic     ref_clk = 1'b0;
   logic     rst_b   = 1'b0;
   logic     ext_low = 1'b0;
   logic     pwr_low = 1'b0;
   logic     soft_pad, pwr_pad, out, oe, core_rst_n, por_rst_n, dbg_rst_n, run_en;
   int       fail_count = 0;
   int       n_checks   = 0;
   int       cyc = 0, hi = 0, lo = 0, bursts = 0, k = 0;
   logic     core_low = 1'b0;
   rpc_row_t rows [3] = '{'{5, 1}, '{14, 2}, '{32, 4}};

   always #25 ref_clk = ~ref_clk;

   rpc_pad_model pads (.ext_low(ext_low), .pwr_low(pwr_low), .oe(oe), .out(out),
                       .soft_pad(soft_pad), .pwr_pad(pwr_pad));
   rpc_reset_pin_controller dut (.ref_clk(ref_clk), .rst_b(rst_b),
      .soft_reset_pin_n_in(soft_pad), .soft_reset_pin_n_out(out),
      .soft_reset_pin_n_oe(oe), .power_reset_pin_n_in(pwr_pad),
      .core_rst_n(core_rst_n), .por_rst_n(por_rst_n), .dbg_rst_n(dbg_rst_n),
      .run_en(run_en));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic cycles(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   task automatic wait_high(ref logic sig);
      k = 0;
      // look on the falling edge, where the design's outputs have settled
      while (sig !== 1'b1 && k < 100) begin
         @(negedge ref_clk);
         k++;
      end
      if (sig !== 1'b1) fail_count++;
   endtask

   // burst monitor: counts drive-low runs and the released gaps between them
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 4000) begin
         fail_count++;
         close_out();
      end else if (rst_b && por_rst_n === 1'b1) begin
         if (oe === 1'b1) begin
            check(soft_pad, 1'b0);
            if (hi == 0 && lo > 0) check(lo, rpc_pkg::SETTLE_CYCLES);
            if (hi == 0) bursts++;
            hi++;
            lo = 0;
         end else begin
            if (hi > 0) check(hi, rpc_pkg::DRIVE_CYCLES);
            hi = 0;
            lo = (core_rst_n === 1'b1) ? 0 : lo + 1;
         end
         if (core_rst_n === 1'b0) core_low = 1'b1;
      end else begin
         // a reset or power hold cuts any burst short; count afresh afterwards
         hi = 0;
         lo = 0;
      end
   end

   initial begin
      cycles(10);
      check({oe, core_rst_n, por_rst_n, dbg_rst_n, run_en}, 8'h00);
      cycles(10);
      rst_b = 1'b1;
      wait_high(run_en);
      // power pin low: everything held, soft pin sensing refused
      pwr_low = 1'b1;
      ext_low = 1'b1;
      cycles(8);
      check({oe, core_rst_n, por_rst_n, dbg_rst_n, run_en}, 8'h00);
      ext_low = 1'b0;
      // release, then pull low again mid-stretch: stretch must restart
      pwr_low = 1'b0;
      cycles(8);
      pwr_low = 1'b1;
      cycles(4);
      check({por_rst_n, run_en}, 8'h00);
      pwr_low = 1'b0;
      wait_high(por_rst_n);
      check(k >= rpc_pkg::POR_HOLD_CYCLES + 2 && k <= rpc_pkg::POR_HOLD_CYCLES + 4, 1'b1);
      check({dbg_rst_n, run_en}, 8'h02);
      cycles(1);
      check({run_en, core_rst_n}, 8'h03);
      $display("power reset test done");
      foreach (rows[i]) begin
         bursts   = 0;
         core_low = 1'b0;
         ext_low  = 1'b1;
         cycles(rows[i].hold);
         ext_low = 1'b0;
         wait_high(core_rst_n);
         cycles(2);
         check(bursts, rows[i].bursts);
         check(core_low, 1'b1);
         check({core_rst_n, por_rst_n, dbg_rst_n, run_en}, 8'h0f);
         $display("soft reset row %0d done", i);
      end
      // reset in the middle of a burst releases the pad at once
      ext_low = 1'b1;
      cycles(6);
      rst_b = 1'b0;
      cycles(2);
      check({oe, core_rst_n, por_rst_n, dbg_rst_n, run_en}, 8'h00);
      ext_low = 1'b0;
      rst_b   = 1'b1;
      wait_high(run_en);
      check({core_rst_n, por_rst_n, oe}, 8'h06);
      $display("mid-burst reset test done");
      close_out();
   end
endmodule
`default_nettype wire
